// File: asfl_core.sv
`timescale 1ns/1ps
module asfl_core #(
    parameter int P_BIT_CYC = 104                 // system clocks per serial bit
)(
    input  wire logic        I_CLK_SYS,           // system clock, 200 MHz
    input  wire logic        I_RST_B,             // synchronous reset, active low
    input  wire logic        I_PSEL,              // apb select
    input  wire logic        I_PENABLE,           // apb access phase
    input  wire logic        I_PWRITE,            // apb direction, high = write
    input  wire logic [9:0]  I_PADDR,             // apb byte address
    input  wire logic [31:0] I_PWDATA,            // apb write data
    input  wire logic        I_RXD,               // serial input pin
    output logic             O_PREADY,            // apb ready, always high
    output logic             O_PSLVERR,           // apb error on unmapped address
    output logic      [31:0] O_PRDATA,            // apb read data
    output logic             O_TXD,               // serial output pin
    output logic             O_TX_IRQ,            // transmitter interrupt request
    output logic             O_RX_IRQ             // receiver interrupt request
);
    localparam int              TW       = $clog2(P_BIT_CYC + 1);
    localparam logic [TW-1:0]   BIT_LAST = TW'(P_BIT_CYC - 1);
    localparam logic [TW-1:0]   BIT_HALF = TW'(P_BIT_CYC / 2);
    localparam logic [TW-1:0]   TMR_ZERO = TW'(0);

    logic [7:0]  ctrl_one_q, ctrl_two_q, ctrl_two_d, status;
    logic [8:0]  txbuf_q, tx_char, rx_data_q, rx_char;
    logic [10:0] tx_sh_q, ld_sh, rx_sh_q, rx_nsh;
    logic [3:0]  tx_bits_q, ld_cnt, rx_cnt_q, rx_qcnt_q, frame_len;
    logic [TW-1:0] tx_tmr_q, rx_tmr_q;
    logic [31:0] prdata_q, rd_mux;
    asfl_pkg::asfl_tx_e tx_st_q;
    asfl_pkg::asfl_rx_e rx_st_q;
    logic loop_on, module_on, flip, char_len, wake_sel, quiet_sel, par_on, par_odd;
    logic txe_en, txd_en, rxf_en, qt_en, tx_on, rx_on, standby, send_break_ctl;
    logic acc, sel_c1, sel_c2, sel_st, sel_dt, mapped, wr, rd_dat;
    logic tx_empty_q, tx_pre_q, tx_tail_q, tx_on_prev_q, txd_q, tx_done, tx_raw;
    logic tx_tick, tx_free, tx_go, ld_brk, ld_tail, ld_pre, ld_dat, ld_any;
    logic rx_line, rx_live, rx_tick, rx_start, rx_done, rx_false, rx_prev_q;
    logic rx_msb, rx_perr, rx_store, addr_wake, idle_wake, wake, q_ok, q_hit, idle_set;
    logic rx_full_q, idle_q, perr_q, ferr_q, idle_arm_q;

    // control field views
    assign loop_on   = ctrl_one_q[asfl_pkg::C1_LOOP];
    assign module_on = ctrl_one_q[asfl_pkg::C1_MOD_ON];
    assign flip      = ctrl_one_q[asfl_pkg::C1_FLIP];
    assign char_len  = ctrl_one_q[asfl_pkg::C1_LONG];
    assign wake_sel  = ctrl_one_q[asfl_pkg::C1_WAKE_ADR];
    assign quiet_sel = ctrl_one_q[asfl_pkg::C1_QSTART];
    assign par_on    = ctrl_one_q[asfl_pkg::C1_PAR_ON];
    assign par_odd   = ctrl_one_q[asfl_pkg::C1_PAR_ODD];
    assign txe_en    = ctrl_two_q[asfl_pkg::C2_TXE_EN];
    assign txd_en    = ctrl_two_q[asfl_pkg::C2_TXD_EN];
    assign rxf_en    = ctrl_two_q[asfl_pkg::C2_RXF_EN];
    assign qt_en     = ctrl_two_q[asfl_pkg::C2_QT_EN];
    assign tx_on     = ctrl_two_q[asfl_pkg::C2_TX_ON];
    assign rx_on     = ctrl_two_q[asfl_pkg::C2_RX_ON];
    assign standby   = ctrl_two_q[asfl_pkg::C2_STANDBY];
    assign send_break_ctl       = ctrl_two_q[asfl_pkg::C2_BREAK];
    assign frame_len = char_len ? asfl_pkg::FRAME_LONG : asfl_pkg::FRAME_SHORT;

    // apb decode; zero wait states because read data is captured in setup
    assign sel_c1    = I_PADDR[9:2] == asfl_pkg::IDX_CTRL_ONE;
    assign sel_c2    = I_PADDR[9:2] == asfl_pkg::IDX_CTRL_TWO;
    assign sel_st    = I_PADDR[9:2] == asfl_pkg::IDX_STATUS;
    assign sel_dt    = I_PADDR[9:2] == asfl_pkg::IDX_DATA;
    assign mapped    = sel_c1 | sel_c2 | sel_st | sel_dt;
    assign acc       = I_PSEL & I_PENABLE;
    assign wr        = acc & I_PWRITE & mapped;
    assign rd_dat    = acc & ~I_PWRITE & sel_dt;
    assign O_PREADY  = 1'b1;
    assign O_PSLVERR = acc & ~mapped;
    assign O_PRDATA  = prdata_q;

    // status view and read mux
    always_comb
    begin
        status = asfl_pkg::CTRL_RST;
        status[asfl_pkg::ST_TX_EMPTY] = tx_empty_q;
        status[asfl_pkg::ST_TX_DONE]  = tx_done;
        status[asfl_pkg::ST_RX_FULL]  = rx_full_q;
        status[asfl_pkg::ST_QUIET]    = idle_q;
        status[asfl_pkg::ST_FRM_ERR]  = ferr_q;
        status[asfl_pkg::ST_PAR_ERR]  = perr_q;
        rd_mux = asfl_pkg::RD_ZERO;
        if (sel_c1)
            rd_mux[7:0] = ctrl_one_q;
        if (sel_c2)
            rd_mux[7:0] = ctrl_two_q;
        if (sel_st)
            rd_mux[7:0] = status;
        if (sel_dt)
            rd_mux[8:0] = rx_data_q;
    end

    // read data flop, loaded in the setup cycle
    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RST_B)
            prdata_q <= asfl_pkg::RD_ZERO;
        else if (I_PSEL & ~I_PENABLE & ~I_PWRITE)
            prdata_q <= rd_mux;
    end

    // ctrl_one
    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RST_B)
            ctrl_one_q <= asfl_pkg::CTRL_RST;
        else if (wr & sel_c1)
            ctrl_one_q <= I_PWDATA[7:0];
    end

    // ctrl_two; a wake clears standby, a write in the same cycle wins so software can re-arm
    always_comb
    begin
        ctrl_two_d = ctrl_two_q;
        if (wake)
            ctrl_two_d[asfl_pkg::C2_STANDBY] = 1'b0;
        if (wr & sel_c2)
            ctrl_two_d = I_PWDATA[7:0];
    end

    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RST_B)
            ctrl_two_q <= asfl_pkg::CTRL_RST;
        else
            ctrl_two_q <= ctrl_two_d;
    end

    // transmit buffer and empty flag; the hardware set beats a data write
    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RST_B)
            txbuf_q <= asfl_pkg::DATA_RST;
        else if (wr & sel_dt)
            txbuf_q <= I_PWDATA[8:0];
    end

    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RST_B)
            tx_empty_q <= 1'b1;
        else if (ld_dat | ~module_on)
            tx_empty_q <= 1'b1;
        else if (wr & sel_dt)
            tx_empty_q <= 1'b0;
    end

    // load decision; deciding in the last bit cycle keeps frames back to back
    assign tx_tick = tx_tmr_q == BIT_LAST;
    assign tx_free = (tx_st_q == asfl_pkg::TX_IDLE) | (tx_tick & (tx_bits_q == asfl_pkg::TAIL_BITS));
    assign tx_go   = tx_free & tx_on & module_on;
    assign ld_brk  = tx_go & send_break_ctl;
    assign ld_tail = tx_go & ~send_break_ctl & tx_tail_q;
    assign ld_pre  = tx_go & ~send_break_ctl & ~tx_tail_q & tx_pre_q;
    assign ld_dat  = tx_go & ~send_break_ctl & ~tx_tail_q & ~tx_pre_q & ~tx_empty_q;
    assign ld_any  = ld_brk | ld_tail | ld_pre | ld_dat;
    assign tx_raw  = (tx_st_q == asfl_pkg::TX_SEND) ? tx_sh_q[0] : 1'b1;
    assign tx_done = ~module_on | (tx_empty_q & (tx_st_q == asfl_pkg::TX_IDLE)
                     & ~tx_pre_q & ~tx_tail_q & ~(send_break_ctl & tx_on));

    // frame image, start bit in bit 0
    always_comb
    begin
        tx_char = txbuf_q;
        if (par_on & char_len)
            tx_char[8] = ^txbuf_q[7:0] ^ par_odd;
        else if (par_on)
            tx_char[7] = ^txbuf_q[6:0] ^ par_odd;
        if (ld_brk)
            ld_sh = asfl_pkg::SH_ZERO;
        else if (ld_dat & char_len)
            ld_sh = {1'b1, tx_char, 1'b0};
        else if (ld_dat)
            ld_sh = {2'b11, tx_char[7:0], 1'b0};
        else
            ld_sh = asfl_pkg::SH_ONES;
        ld_cnt = ld_tail ? asfl_pkg::TAIL_BITS : frame_len;
    end

    // transmit shifter; module off aborts at once
    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RST_B || !module_on)
        begin
            tx_st_q   <= asfl_pkg::TX_IDLE;
            tx_sh_q   <= asfl_pkg::SH_ONES;
            tx_bits_q <= asfl_pkg::CNT_ZERO;
            tx_tmr_q  <= TMR_ZERO;
        end
        else if (ld_any)
        begin
            tx_st_q   <= asfl_pkg::TX_SEND;
            tx_sh_q   <= ld_sh;
            tx_bits_q <= ld_cnt;
            tx_tmr_q  <= TMR_ZERO;
        end
        else if (tx_st_q == asfl_pkg::TX_SEND)
        begin
            tx_tmr_q <= tx_tick ? TMR_ZERO : tx_tmr_q + 1'b1;
            if (tx_tick && tx_bits_q == asfl_pkg::TAIL_BITS)
                tx_st_q <= asfl_pkg::TX_IDLE;
            if (tx_tick)
            begin
                tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
                tx_bits_q <= tx_bits_q - 4'h1;
            end
        end
    end

    // pending preamble and post-break high bit; a new request beats its own consume
    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RST_B || !module_on)
        begin
            tx_on_prev_q <= 1'b0;
            tx_pre_q     <= 1'b0;
            tx_tail_q    <= 1'b0;
        end
        else
        begin
            tx_on_prev_q <= tx_on;
            if (tx_on & ~tx_on_prev_q)
                tx_pre_q <= 1'b1;
            else if (ld_pre | ld_brk)
                tx_pre_q <= 1'b0;
            if (ld_brk)
                tx_tail_q <= 1'b1;
            else if (ld_tail)
                tx_tail_q <= 1'b0;
        end
    end

    // pin flop; inversion covers idle too
    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RST_B)
            txd_q <= 1'b1;
        else
            txd_q <= tx_raw ^ flip;
    end
    assign O_TXD = txd_q;

    // receiver input and frame decode
    assign rx_line   = loop_on ? tx_raw : I_RXD;
    assign rx_live   = rx_on & module_on;
    assign rx_tick   = rx_tmr_q == TMR_ZERO;
    assign rx_start  = (rx_st_q == asfl_pkg::RX_IDLE) & rx_live & rx_prev_q & ~rx_line;
    assign rx_nsh    = {rx_line, rx_sh_q[10:1]};
    assign rx_done   = (rx_st_q == asfl_pkg::RX_BITS) & rx_tick & (rx_cnt_q == asfl_pkg::TAIL_BITS);
    assign rx_false  = (rx_st_q == asfl_pkg::RX_BITS) & rx_tick & (rx_cnt_q == frame_len) & rx_line;
    assign rx_char   = char_len ? rx_nsh[9:1] : {rx_nsh[9], rx_nsh[9:2]};
    assign rx_msb    = rx_nsh[9];
    assign rx_perr   = par_on & ((char_len ? ^rx_nsh[9:1] : ^rx_nsh[9:2]) ^ par_odd);
    assign addr_wake = rx_done & standby & wake_sel & rx_msb;
    assign rx_store  = rx_done & (~standby | addr_wake);

    // receive sampler; timer also free-runs in idle to pace the quiet count
    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RST_B || !rx_live)
        begin
            rx_st_q  <= asfl_pkg::RX_IDLE;
            rx_tmr_q <= BIT_LAST;
            rx_cnt_q <= asfl_pkg::CNT_ZERO;
            rx_sh_q  <= asfl_pkg::SH_ONES;
        end
        else if (rx_start)
        begin
            rx_st_q  <= asfl_pkg::RX_BITS;
            rx_tmr_q <= BIT_HALF;
            rx_cnt_q <= frame_len;
        end
        else
        begin
            rx_tmr_q <= rx_tick ? BIT_LAST : rx_tmr_q - 1'b1;
            if (rx_st_q == asfl_pkg::RX_BITS && rx_tick)
            begin
                rx_sh_q  <= rx_nsh;
                rx_cnt_q <= rx_cnt_q - 4'h1;
            end
            if (rx_done | rx_false)
                rx_st_q <= asfl_pkg::RX_IDLE;
        end
    end

    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RST_B)
            rx_prev_q <= 1'b1;
        else
            rx_prev_q <= rx_line;
    end

    // quiet counter; with the after-stop choice ones inside a frame never count
    assign q_ok      = (rx_st_q == asfl_pkg::RX_IDLE) | ~quiet_sel;
    assign q_hit     = rx_live & rx_tick & rx_line & q_ok & (rx_qcnt_q != frame_len)
                       & (rx_qcnt_q + 4'h1 == frame_len);
    assign idle_wake = q_hit & standby & ~wake_sel;
    assign wake      = addr_wake | idle_wake;
    assign idle_set  = q_hit & ~standby & idle_arm_q;

    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RST_B || !rx_live || rx_start)
            rx_qcnt_q <= asfl_pkg::CNT_ZERO;
        else if (rx_tick && rx_line && q_ok && rx_qcnt_q != frame_len)
            rx_qcnt_q <= rx_qcnt_q + 4'h1;
        else if (rx_tick && !(rx_line && q_ok))
            rx_qcnt_q <= asfl_pkg::CNT_ZERO;
    end

    // receiver flags; a hardware set beats the data-read clear; rx-on does not touch them
    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RST_B)
        begin
            rx_full_q  <= 1'b0;
            idle_q     <= 1'b0;
            perr_q     <= 1'b0;
            ferr_q     <= 1'b0;
            idle_arm_q <= 1'b0;
            rx_data_q  <= asfl_pkg::DATA_RST;
        end
        else
        begin
            rx_full_q  <= rx_store | (rx_full_q & ~rd_dat);
            idle_q     <= idle_set | (idle_q & ~rd_dat);
            perr_q     <= (rx_store & rx_perr) | (perr_q & ~rd_dat);
            ferr_q     <= (rx_store & ~rx_line) | (ferr_q & ~rd_dat);
            idle_arm_q <= rx_store | (idle_arm_q & ~idle_set);
            if (rx_store)
                rx_data_q <= rx_char;
        end
    end

    // interrupt requests, level outputs
    assign O_TX_IRQ = module_on & ((tx_empty_q & txe_en) | (tx_done & txd_en));
    assign O_RX_IRQ = ~standby & ((rx_full_q & rxf_en) | (idle_q & qt_en));

    // checks
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_B);

    property p_loop;
        loop_on |=> (O_TXD ^ $past(flip)) == $past(rx_line);
    endproperty
    a_loop: assert property (p_loop) else $error("loopback path broken");
    property p_off;
        !module_on |-> (tx_done && !O_TX_IRQ) ##1 tx_empty_q;
    endproperty
    a_off: assert property (p_off) else $error("module off flags wrong");
    property p_flip;
        tx_st_q == asfl_pkg::TX_IDLE && !ld_any && flip |=> !O_TXD;
    endproperty
    a_flip: assert property (p_flip) else $error("idle not inverted");
    property p_len;
        ld_pre || ld_dat || ld_brk |=> tx_bits_q == $past(frame_len);
    endproperty
    a_len: assert property (p_len) else $error("frame length wrong");
    property p_par;
        ld_dat && par_on |-> (char_len ? ^ld_sh[9:1] : ^ld_sh[8:1]) == par_odd;
    endproperty
    a_par: assert property (p_par) else $error("parity bit wrong");
    property p_pre;
        $rose(tx_on) && module_on |=> tx_pre_q;
    endproperty
    a_pre: assert property (p_pre) else $error("preamble not queued");
    property p_hold;
        !tx_on && tx_st_q == asfl_pkg::TX_IDLE |=> tx_st_q == asfl_pkg::TX_IDLE;
    endproperty
    a_hold: assert property (p_hold) else $error("sent while off");
    property p_brk;
        ld_brk |=> tx_sh_q == asfl_pkg::SH_ZERO && tx_tail_q;
    endproperty
    a_brk: assert property (p_brk) else $error("break frame wrong");
    property p_tail;
        ld_tail |=> tx_sh_q[0] && tx_bits_q == asfl_pkg::TAIL_BITS;
    endproperty
    a_tail: assert property (p_tail) else $error("no high bit after break");
    property p_empty;
        ld_dat |=> tx_empty_q;
    endproperty
    a_empty: assert property (p_empty) else $error("empty not set on load");
    property p_wake;
        addr_wake && !(wr && sel_c2) |=> !standby && rx_full_q;
    endproperty
    a_wake: assert property (p_wake) else $error("address wake wrong");
    property p_rxirq;
        standby |-> !O_RX_IRQ;
    endproperty
    a_rxirq: assert property (p_rxirq) else $error("irq during standby");
    property p_txirq;
        module_on && txe_en && tx_empty_q |-> O_TX_IRQ;
    endproperty
    a_txirq: assert property (p_txirq) else $error("empty irq missing");
    property p_rxoff;
        !rx_on |=> rx_st_q == asfl_pkg::RX_IDLE;
    endproperty
    a_rxoff: assert property (p_rxoff) else $error("receiving while off");
    c_brk: cover property (ld_brk ##1 !send_break_ctl [*2]);
    c_wake: cover property (addr_wake);
    c_iwake: cover property (idle_wake);
    c_idle: cover property (idle_set);
endmodule

// File: asfl_peer.sv
`timescale 1ns/1ps
// remote serial sender; the line idles high between frames like a pulled-up wire
module asfl_peer (
    input  wire logic i_clk,             // bench clock
    output logic      o_rxd              // serial line into the unit
);
    initial o_rxd = 1'b1;
    // bits go out lsb first, each held a whole bit time
    task automatic send(input logic [10:0] b, input int n, input int p);
        for (int i = 0; i < n; i++)
        begin
            @(posedge i_clk);
            o_rxd <= b[i];
            repeat (p - 1) @(posedge i_clk);
        end
        @(posedge i_clk);
        o_rxd <= 1'b1;
    endtask
endmodule

// File: asfl_pkg.sv
package asfl_pkg;
    // register indices; the bus byte address is four times the index
    localparam logic [7:0]  IDX_CTRL_ONE = 8'h13;
    localparam logic [7:0]  IDX_CTRL_TWO = 8'h14;
    localparam logic [7:0]  IDX_STATUS   = 8'h16;
    localparam logic [7:0]  IDX_DATA     = 8'h17;
    localparam logic [7:0]  CTRL_RST     = 8'h00;
    localparam logic [8:0]  DATA_RST     = 9'h000;
    localparam logic [31:0] RD_ZERO      = 32'h0000_0000;
    // ctrl_one field positions
    localparam int C1_LOOP     = 7;
    localparam int C1_MOD_ON   = 6;
    localparam int C1_FLIP     = 5;
    localparam int C1_LONG     = 4;
    localparam int C1_WAKE_ADR = 3;
    localparam int C1_QSTART   = 2;
    localparam int C1_PAR_ON   = 1;
    localparam int C1_PAR_ODD  = 0;
    // ctrl_two field positions
    localparam int C2_TXE_EN   = 7;
    localparam int C2_TXD_EN   = 6;
    localparam int C2_RXF_EN   = 5;
    localparam int C2_QT_EN    = 4;
    localparam int C2_TX_ON    = 3;
    localparam int C2_RX_ON    = 2;
    localparam int C2_STANDBY  = 1;
    localparam int C2_BREAK    = 0;
    // status field positions
    localparam int ST_TX_EMPTY = 7;
    localparam int ST_TX_DONE  = 6;
    localparam int ST_RX_FULL  = 5;
    localparam int ST_QUIET    = 4;
    localparam int ST_FRM_ERR  = 1;
    localparam int ST_PAR_ERR  = 0;
    // frame lengths in bit times
    localparam logic [3:0]  FRAME_SHORT  = 4'ha;
    localparam logic [3:0]  FRAME_LONG   = 4'hb;
    localparam logic [3:0]  TAIL_BITS    = 4'h1;
    localparam logic [3:0]  CNT_ZERO     = 4'h0;
    localparam logic [10:0] SH_ONES      = 11'h7ff;
    localparam logic [10:0] SH_ZERO      = 11'h000;
    typedef enum {TX_IDLE, TX_SEND} asfl_tx_e;
    typedef enum {RX_IDLE, RX_BITS} asfl_rx_e;
endpackage

// File: test_async_serial_frame_and_link_control.sv
`timescale 1ns/1ps
module test_async_serial_frame_and_link_control;
    localparam int P = 16;
    logic        clk, rst_b, psel, penable, pwrite, rxd, pready, pslverr, txd, tx_irq, rx_irq, err;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [8:0]  d;
    logic [10:0] f;
    logic [3:0]  m;
    int          miscompares, tests_run, cnt;
    integer      seed;
    asfl_core #(.P_BIT_CYC(P)) asfl_core_i (.I_CLK_SYS(clk), .I_RST_B(rst_b), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_RXD(rxd),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .O_PRDATA(prdata), .O_TXD(txd),
        .O_TX_IRQ(tx_irq), .O_RX_IRQ(rx_irq));
    asfl_peer asfl_peer_i (.i_clk(clk), .o_rxd(rxd));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e)
        begin
            $display("Error %s expected %h seen %h", nm, e, s);
            miscompares++;
        end
    endtask
    task finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // one apb transfer; the request stands until pready is seen at an edge
    task apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // return off the edge so callers look at outputs that have settled
        @(negedge clk);
    endtask
    // expected line bits, lsb first: start, data with parity on top, stop
    function automatic logic [10:0] frm(input logic [8:0] dd, input logic lg, pe, od);
        logic [8:0] x;
        x = dd;
        if (pe && lg)
            x[8] = ^dd[7:0] ^ od;
        if (pe && !lg)
            x[7] = ^dd[6:0] ^ od;
        frm = lg ? {1'b1, x, 1'b0} : {2'b11, x[7:0], 1'b0};
    endfunction
    // waits out the preamble, then samples each bit in its middle
    task txchk(input int nb, input logic fl);
        cnt = 0;
        while (txd !== fl && cnt < 40 * P)
        begin
            @(posedge clk);
            cnt++;
        end
        chk("preamble", 32'(cnt + 8 >= nb * P && cnt <= nb * P + 4), 32'h1);
        repeat (P / 2) @(posedge clk);
        for (int i = 0; i < nb; i++)
        begin
            chk("txd", 32'(txd), 32'(f[i] ^ fl));
            repeat (P) @(posedge clk);
        end
    endtask
    // hang guard, far beyond the few thousand cycles the run needs
    initial
    begin
        repeat (60000) @(posedge clk);
        miscompares++;
        finish_test;
    end
    initial
    begin
        seed = 32'h97747d49;
        {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        apb(0, asfl_pkg::IDX_CTRL_ONE, 0);
        chk("ctrl_one", rd, 32'h0);
        apb(0, asfl_pkg::IDX_STATUS, 0);
        chk("status", rd & 32'hc0, 32'hc0);
        apb(0, 8'h20, 0);
        chk("unmapped", {rd[30:0], err}, 32'h1);
        chk("pready", 32'(pready), 32'h1);
        for (int k = 0; k < 4; k++)
        begin
            d = 9'($random(seed)) | 9'h040;
            apb(1, asfl_pkg::IDX_CTRL_ONE, {24'h0, d[7:0]});
            apb(0, asfl_pkg::IDX_CTRL_ONE, 0);
            chk("ctrl_one", rd, {24'h0, d[7:0]});
        end
        apb(1, asfl_pkg::IDX_CTRL_ONE, 32'h40);
        apb(1, asfl_pkg::IDX_CTRL_TWO, 32'h80);
        chk("tx_irq", 32'(tx_irq), 32'h1);
        apb(1, asfl_pkg::IDX_CTRL_TWO, 32'h40);
        chk("tx_irq", 32'(tx_irq), 32'h1);
        apb(1, asfl_pkg::IDX_CTRL_TWO, 32'h00);
        chk("tx_irq", 32'(tx_irq), 32'h0);
        apb(1, asfl_pkg::IDX_CTRL_ONE, 32'h00);
        apb(1, asfl_pkg::IDX_CTRL_TWO, 32'hc0);
        chk("tx_irq", 32'(tx_irq), 32'h0);
        // loopback frames in both lengths and both polarities, parity off and odd, plus random mixes
        for (int k = 0; k < 6; k++)
        begin
            m = (k == 0) ? 4'h0 : (k == 1) ? 4'hf : (k == 2) ? 4'h6 : 4'($random(seed));
            d = 9'($random(seed));
            apb(1, asfl_pkg::IDX_CTRL_ONE, {24'h0, 2'b11, m[0], m[3], 2'b00, m[2], m[1]});
            apb(1, asfl_pkg::IDX_CTRL_TWO, 32'h04);
            apb(1, asfl_pkg::IDX_CTRL_TWO, 32'h2c);
            apb(1, asfl_pkg::IDX_DATA, {23'h0, d});
            f = frm(d, m[3], m[2], m[1]);
            txchk(m[3] ? 11 : 10, m[0]);
            chk("rx_irq", 32'(rx_irq), 32'h1);
            apb(0, asfl_pkg::IDX_DATA, 0);
            chk("rx_data", 32'(rd[8:0]), 32'(m[3] ? f[9:1] : {f[8], f[8:1]}));
            @(posedge clk);
            chk("rx_irq", 32'(rx_irq), 32'h0);
        end
        // frame from the peer, then receiver off must keep its flag
        apb(1, asfl_pkg::IDX_CTRL_ONE, 32'h40);
        apb(1, asfl_pkg::IDX_CTRL_TWO, 32'h24);
        d = 9'($random(seed));
        asfl_peer_i.send({2'b11, d[7:0], 1'b0}, 10, P);
        repeat (4) @(posedge clk);
        chk("rx_irq", 32'(rx_irq), 32'h1);
        apb(1, asfl_pkg::IDX_CTRL_TWO, 32'h20);
        chk("rx_irq", 32'(rx_irq), 32'h1);
        apb(0, asfl_pkg::IDX_DATA, 0);
        chk("rx_data", 32'(rd[7:0]), 32'(d[7:0]));
        // address-mark standby: a plain character is ignored, a marked one wakes and is stored
        apb(1, asfl_pkg::IDX_CTRL_ONE, 32'h48);
        apb(1, asfl_pkg::IDX_CTRL_TWO, 32'h26);
        d = 9'($random(seed));
        asfl_peer_i.send({2'b11, 1'b0, d[6:0], 1'b0}, 10, P);
        repeat (4) @(posedge clk);
        apb(0, asfl_pkg::IDX_CTRL_TWO, 0);
        chk("standby", rd, 32'h26);
        asfl_peer_i.send({2'b11, 1'b1, d[6:0], 1'b0}, 10, P);
        repeat (4) @(posedge clk);
        chk("rx_irq", 32'(rx_irq), 32'h1);
        apb(0, asfl_pkg::IDX_CTRL_TWO, 0);
        chk("standby", rd, 32'h24);
        apb(0, asfl_pkg::IDX_DATA, 0);
        chk("rx_data", 32'(rd[7:0]), {24'h0, 1'b1, d[6:0]});
        // the quiet line after a stored character raises the idle request
        apb(1, asfl_pkg::IDX_CTRL_TWO, 32'h14);
        repeat (12 * P) @(posedge clk);
        chk("rx_irq", 32'(rx_irq), 32'h1);
        // break held: no ones at all; break cleared: one high bit before the queued character
        apb(1, asfl_pkg::IDX_CTRL_TWO, 32'h08);
        repeat (12 * P) @(posedge clk);
        apb(1, asfl_pkg::IDX_CTRL_TWO, 32'h09);
        repeat (4) @(posedge clk);
        cnt = 0;
        repeat (20 * P)
        begin
            @(posedge clk);
            cnt += txd;
        end
        chk("break_ones", cnt, 0);
        apb(1, asfl_pkg::IDX_DATA, {23'h0, d});
        apb(1, asfl_pkg::IDX_CTRL_TWO, 32'h08);
        cnt = 0;
        while (txd !== 1'b1 && cnt < 30 * P)
        begin
            @(posedge clk);
            cnt++;
        end
        cnt = 0;
        while (txd === 1'b1 && cnt < 4 * P)
        begin
            @(posedge clk);
            cnt++;
        end
        chk("break_gap", cnt, P);
        finish_test;
    end
endmodule
